// ---- src/scss_clock_select.sv ----
// System clock source select: picks fast and slow sources, divides the
// fast clock, switches glitch-free and gates clocks in halt.
// Assumes one hclk; every produced clock is a one-cycle enable pulse.
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Fast clock comes from fast crystal or fast RC per fast source bit.
// - Slow clock comes from slow crystal or slow RC per slow source bit.
// - Three-bit select picks fast path or slow clock as system clock.
// - Fast clock also offered divided by 2, 4, 8, 16, 32 and 64.
// - Fast RC frequency is one of three options fixed at programming.
// - Slow crystal starts when its enable bit and its pin-share bit are both 1.
// - Slow RC gives a slow clock candidate with no external parts.
// - Halt gates off the system clock.
// - A clock independent of system clock keeps timers running in halt.
// - Pin-share bit gives slow crystal pins to oscillator or to I/O.
// - Fast RC selected leaves fast crystal pins free for I/O.
// - In slow mode the fast oscillator stops or runs per its enable bit.
// - Codes 0 to 6 divide fast clock by 1 to 64, code 7 is slow.
// - Fast source bit: 0 fast RC, 1 fast crystal.
// - Slow source bit: 0 slow RC, 1 slow crystal.
// - Switch takes four current ticks plus a target edge.
module scss_clock_select
  import scss_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Oscillator pins
  input wire logic int_fast_rc_osc_in,
  input wire logic ext_fast_crystal_osc_in,
  input wire logic int_slow_rc_osc_in,
  input wire logic ext_slow_crystal_osc_in,
  input wire logic [1:0] fast_rc_opt,
  // Core status
  input wire logic cpu_halt,
  // Oscillator enables and trim
  output logic int_fast_rc_osc_en,
  output logic ext_fast_crystal_osc_en,
  output logic int_slow_rc_osc_en,
  output logic ext_slow_crystal_osc_en,
  output logic [1:0] fast_rc_freq_field,
  // Pin sharing
  output logic fast_crystal_pins_osc_sel,
  output logic slow_crystal_pins_osc_sel,
  // Clock enables
  output logic sysclk_en,
  output logic fast_periph_en,
  output logic slow_periph_en,
  output logic timer_tick
);

  // ****************************************************************
  // Oscillator tick synchronisers
  // ****************************************************************
  logic [3:0] osc_pin;
  logic [3:0] osc_tick;
  assign osc_pin = {ext_slow_crystal_osc_in, int_slow_rc_osc_in,
                    ext_fast_crystal_osc_in, int_fast_rc_osc_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      scss_tick_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .osc_in(osc_pin[gi]),
        .tick(osc_tick[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] scc_ff;
  logic [1:0] frc_freq_ff;
  logic frc_en_ff;
  logic fxt_en_ff;
  logic sxt_en_ff;
  logic sxt_pin_ff;
  logic [10:0] fxt_cnt_ff;
  logic [10:0] sxt_cnt_ff;
  logic [1:0] opt_s1_ff;
  logic [1:0] opt_s2_ff;
  logic [1:0] opt_ff;
  logic opt_done_ff;
  logic [1:0] opt_age_ff;
  logic [2:0] act_div_ff;
  logic act_fast_ff;
  logic act_slow_ff;
  logic [5:0] div_cnt_ff;
  logic [2:0] drain_ff;
  scss_state_t state_ff;
  scss_state_t nxt_state;
  logic wr_pend_ff;
  logic [7:0] addr_ff;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire addr_take = hsel & hready & htrans[1];
  wire wr_scc = wr_pend_ff & (addr_ff == SCSS_OFS_SYSCLK_CTRL);
  wire wr_frc = wr_pend_ff & (addr_ff == SCSS_OFS_FAST_RC_CTRL);
  wire wr_fxt = wr_pend_ff & (addr_ff == SCSS_OFS_FAST_XTAL_CTRL);
  wire wr_sxt = wr_pend_ff & (addr_ff == SCSS_OFS_SLOW_XTAL_CTRL);

  // Zero-wait slave; every access answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture; only whole-word writes are expected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= addr_take & hwrite & (hsize == 3'h2);
      addr_ff <= haddr;
    end
  end

  // Software-written control bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scc_ff <= SCSS_SCC_RST;
      frc_freq_ff <= SCSS_FRC_FREQ_RST;
      frc_en_ff <= SCSS_FRC_EN_RST;
      fxt_en_ff <= 1'b0;
      sxt_en_ff <= 1'b0;
      sxt_pin_ff <= 1'b0;
    end else begin
      if (wr_scc) scc_ff <= hwdata[7:0] & 8'hef;
      if (wr_frc) begin
        frc_freq_ff <= hwdata[SCSS_FRC_FREQ_LSB +: 2];
        frc_en_ff <= hwdata[SCSS_OSC_EN];
      end
      if (wr_fxt) fxt_en_ff <= hwdata[SCSS_OSC_EN];
      if (wr_sxt) begin
        sxt_en_ff <= hwdata[SCSS_OSC_EN];
        sxt_pin_ff <= hwdata[SCSS_SXT_PIN_OSC];
      end
    end
  end

  // Requested selection fields
  wire [2:0] req_div = scc_ff[SCSS_SCC_DIV_LSB +: 3];
  wire req_fast = scc_ff[SCSS_SCC_FAST_SRC];
  wire req_slow = scc_ff[SCSS_SCC_SLOW_SRC];
  wire fast_idle_en = scc_ff[SCSS_SCC_FAST_IDLE];
  wire slow_idle_en = scc_ff[SCSS_SCC_SLOW_IDLE];

  // ****************************************************************
  // Frequency option strap
  // ****************************************************************
  // Strap caught once after release, never loaded by the reset itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_s1_ff <= 2'h0;
      opt_s2_ff <= 2'h0;
      opt_ff <= 2'h0;
      opt_done_ff <= 1'b0;
      opt_age_ff <= 2'h0;
    end else begin
      opt_s1_ff <= fast_rc_opt;
      opt_s2_ff <= opt_s1_ff;
      if (opt_age_ff != 2'h3) opt_age_ff <= opt_age_ff + 2'h1;
      // Second flop holds the strap from the second edge on; caught on the third
      if (opt_age_ff == 2'h2) begin
        opt_ff <= opt_s2_ff;
        opt_done_ff <= 1'b1;
      end
    end
  end

  // Trim follows software; a mismatch only costs accuracy
  assign fast_rc_freq_field = frc_freq_ff;
  wire frc_mismatch = opt_done_ff & (opt_ff != frc_freq_ff);

  // ****************************************************************
  // Oscillator enables and crystal start-up
  // ****************************************************************
  wire awake_fast = ~cpu_halt | fast_idle_en;
  wire awake_slow = ~cpu_halt | slow_idle_en;
  wire act_on_fast = (act_div_ff != SCSS_DIV_SLOW);
  wire req_on_fast = (req_div != SCSS_DIV_SLOW);
  wire frc_used = (act_on_fast & ~act_fast_ff) | (req_on_fast & ~req_fast);
  wire fxt_used = act_on_fast & act_fast_ff;

  // Fast oscillator in slow mode runs only if its enable bit says so
  assign int_fast_rc_osc_en = awake_fast & (frc_used | frc_en_ff);
  assign ext_fast_crystal_osc_en = awake_fast & (fxt_used | fxt_en_ff);
  assign int_slow_rc_osc_en = 1'b1;
  assign ext_slow_crystal_osc_en = sxt_en_ff & sxt_pin_ff;

  // Fast pins go to the oscillator only when it is used or requested; slow pins follow the pin-share bit
  assign slow_crystal_pins_osc_sel = sxt_pin_ff;
  assign fast_crystal_pins_osc_sel = fxt_used | (req_on_fast & req_fast);

  wire fxt_ok = (fxt_cnt_ff == SCSS_FAST_XTAL_START);
  wire sxt_ok = (sxt_cnt_ff == SCSS_SLOW_XTAL_START);

  // Start-up counters restart whenever the crystal is switched off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fxt_cnt_ff <= 11'h000;
      sxt_cnt_ff <= 11'h000;
    end else begin
      if (!ext_fast_crystal_osc_en) fxt_cnt_ff <= 11'h000;
      else if (osc_tick[SCSS_IX_FXT] && !fxt_ok) fxt_cnt_ff <= fxt_cnt_ff + 11'h001;
      if (!ext_slow_crystal_osc_en) sxt_cnt_ff <= 11'h000;
      else if (osc_tick[SCSS_IX_SXT] && !sxt_ok) sxt_cnt_ff <= sxt_cnt_ff + 11'h001;
    end
  end

  // ****************************************************************
  // Source muxes and divider
  // ****************************************************************
  wire fast_tick = act_fast_ff ? osc_tick[SCSS_IX_FXT] : osc_tick[SCSS_IX_FRC];
  wire slow_tick = act_slow_ff ? osc_tick[SCSS_IX_SXT] : osc_tick[SCSS_IX_SRC];
  wire [5:0] div_mask = ~(6'h3f << act_div_ff);
  wire div_hit = &(div_cnt_ff | ~div_mask);
  wire cur_tick = act_on_fast ? fast_tick : slow_tick;
  wire sys_tick = act_on_fast ? (fast_tick & div_hit) : slow_tick;

  // Target edge taken from the requested source, undivided
  wire tgt_fast = req_fast ? osc_tick[SCSS_IX_FXT] : osc_tick[SCSS_IX_FRC];
  wire tgt_slow = req_slow ? osc_tick[SCSS_IX_SXT] : osc_tick[SCSS_IX_SRC];
  wire tgt_tick = req_on_fast ? tgt_fast : tgt_slow;

  // A crystal target waits for its start-up count
  wire tgt_ok = req_on_fast ? (~req_fast | fxt_ok) : (~req_slow | sxt_ok);
  wire pending = {req_div, req_fast, req_slow} != {act_div_ff, act_fast_ff, act_slow_ff};

  // ****************************************************************
  // Switch state machine
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SCSS_RUN: begin
        if (pending && tgt_ok) nxt_state = SCSS_DRAIN;
      end
      SCSS_DRAIN: begin
        if (!pending) nxt_state = SCSS_RUN;
        else if (cur_tick && drain_ff == SCSS_DRAIN_LAST) nxt_state = SCSS_SWAP;
      end
      SCSS_SWAP: begin
        if (!pending || !tgt_ok) nxt_state = SCSS_RUN;
        else if (tgt_tick) nxt_state = SCSS_RUN;
      end
    endcase
  end

  // Active selection changes only on a target edge, so no runt pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= SCSS_RUN;
      drain_ff <= 3'h0;
      act_div_ff <= SCSS_SCC_RST[SCSS_SCC_DIV_LSB +: 3];
      act_fast_ff <= SCSS_SCC_RST[SCSS_SCC_FAST_SRC];
      act_slow_ff <= SCSS_SCC_RST[SCSS_SCC_SLOW_SRC];
      div_cnt_ff <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      if (state_ff != SCSS_DRAIN) drain_ff <= 3'h0;
      else if (cur_tick) drain_ff <= drain_ff + 3'h1;
      if (state_ff == SCSS_SWAP && pending && tgt_ok && tgt_tick) begin
        act_div_ff <= req_div;
        act_fast_ff <= req_fast;
        act_slow_ff <= req_slow;
        div_cnt_ff <= 6'h00;
      end else if (fast_tick) begin
        div_cnt_ff <= div_cnt_ff + 6'h01;
      end
    end
  end

  // ****************************************************************
  // Clock enable outputs
  // ****************************************************************
  // Swap window is held quiet; halt stops the core clock
  assign sysclk_en = sys_tick & (state_ff != SCSS_SWAP) & ~cpu_halt;
  assign fast_periph_en = fast_tick & awake_fast & (act_on_fast | frc_en_ff | fxt_en_ff);
  assign slow_periph_en = slow_tick & awake_slow;
  assign timer_tick = osc_tick[SCSS_IX_SRC];

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire [31:0] rd_scc = {24'h0, scc_ff};
  wire [31:0] rd_frc = {28'h0, frc_freq_ff, 1'b1, frc_en_ff};
  wire [31:0] rd_fxt = {30'h0, fxt_ok, fxt_en_ff};
  wire [31:0] rd_sxt = {29'h0, sxt_pin_ff, sxt_ok, sxt_en_ff};
  wire [31:0] rd_sts = {22'h0, opt_ff, frc_mismatch, cpu_halt, state_ff != SCSS_RUN,
                        act_slow_ff, act_fast_ff, act_div_ff};

  // Unmapped offsets read as zero
  always_comb begin
    unique case (addr_ff)
      SCSS_OFS_SYSCLK_CTRL: hrdata = rd_scc;
      SCSS_OFS_FAST_RC_CTRL: hrdata = rd_frc;
      SCSS_OFS_FAST_XTAL_CTRL: hrdata = rd_fxt;
      SCSS_OFS_SLOW_XTAL_CTRL: hrdata = rd_sxt;
      SCSS_OFS_STATUS: hrdata = rd_sts;
      default: hrdata = 32'h0;
    endcase
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_drain_end;
    state_ff == SCSS_DRAIN && pending && cur_tick && drain_ff == SCSS_DRAIN_LAST;
  endsequence

  a_fast_src_pick: assert property (act_on_fast && !act_fast_ff && sysclk_en
    |-> osc_tick[SCSS_IX_FRC]) else $error("fast RC not used");
  a_slow_src_pick: assert property (!act_on_fast && act_slow_ff && sysclk_en
    |-> osc_tick[SCSS_IX_SXT]) else $error("slow crystal not used");
  a_halt_gates_sys: assert property (cpu_halt |-> !sysclk_en)
    else $error("system clock runs in halt");
  a_div_two_gap: assert property (act_div_ff == 3'h1 && sysclk_en && state_ff == SCSS_RUN
    ##1 $stable(act_div_ff) |-> !sysclk_en) else $error("divide two too fast");
  a_drain_to_swap: assert property (s_drain_end |=> state_ff == SCSS_SWAP)
    else $error("drain did not end");
  a_swap_quiet: assert property (state_ff == SCSS_SWAP |-> !sysclk_en)
    else $error("pulse during swap");
  a_xtal_guard: assert property ($changed(act_slow_ff) && act_slow_ff
    && act_div_ff == SCSS_DIV_SLOW |-> sxt_ok) else $error("unstable crystal taken");
  a_sxt_enable: assert property ($rose(sxt_en_ff) && sxt_pin_ff
    |-> ext_slow_crystal_osc_en) else $error("slow crystal not started");
  a_fast_pins_free: assert property (!act_fast_ff && !req_fast
    |-> !fast_crystal_pins_osc_sel) else $error("fast pins held");
  a_fast_stop_slow: assert property (!act_on_fast && !req_on_fast && !frc_en_ff
    |-> !int_fast_rc_osc_en) else $error("fast RC kept running");

endmodule : scss_clock_select

// ---- src/scss_pkg.sv ----
// Package for the system clock source select block: register map,
// field positions, reset values, start-up counts and FSM states.
// Assumes a 10 MHz hclk and oscillator pins sampled as ticks.
package scss_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] SCSS_OFS_SYSCLK_CTRL = 8'h00;
  localparam logic [7:0] SCSS_OFS_FAST_RC_CTRL = 8'h04;
  localparam logic [7:0] SCSS_OFS_FAST_XTAL_CTRL = 8'h08;
  localparam logic [7:0] SCSS_OFS_SLOW_XTAL_CTRL = 8'h0c;
  localparam logic [7:0] SCSS_OFS_STATUS = 8'h10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SCSS_SCC_DIV_LSB = 5;
  localparam int SCSS_SCC_FAST_SRC = 3;
  localparam int SCSS_SCC_SLOW_SRC = 2;
  localparam int SCSS_SCC_FAST_IDLE = 1;
  localparam int SCSS_SCC_SLOW_IDLE = 0;
  localparam int SCSS_FRC_FREQ_LSB = 2;
  localparam int SCSS_OSC_EN = 0;
  localparam int SCSS_OSC_STABLE = 1;
  localparam int SCSS_SXT_PIN_OSC = 2;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [7:0] SCSS_SCC_RST = 8'h00;
  localparam logic [1:0] SCSS_FRC_FREQ_RST = 2'h0;
  localparam logic SCSS_FRC_EN_RST = 1'b1;
  localparam logic [2:0] SCSS_DIV_SLOW = 3'h7;
  localparam logic [2:0] SCSS_DRAIN_LAST = 3'h3;

  // ****************************************************************
  // Start-up counts, in oscillator ticks
  // ****************************************************************
  localparam logic [10:0] SCSS_SLOW_XTAL_START = 11'h400;
  localparam logic [10:0] SCSS_FAST_XTAL_START = 11'h400;

  // Oscillator index in the tick vector
  localparam int SCSS_IX_FRC = 0;
  localparam int SCSS_IX_FXT = 1;
  localparam int SCSS_IX_SRC = 2;
  localparam int SCSS_IX_SXT = 3;

  typedef enum logic [1:0] {
    SCSS_RUN,
    SCSS_DRAIN,
    SCSS_SWAP
  } scss_state_t;

endpackage : scss_pkg

// ---- src/scss_tick_sync.sv ----
// Two-flop synchroniser plus rising-edge detector for one oscillator pin.
// Assumes the pin toggles much slower than hclk.
`timescale 1ns/1ps
module scss_tick_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pin in, tick out
  input wire logic osc_in,
  output logic tick
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // ****************************************************************
  // Synchroniser; first flop feeds only the second
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= osc_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // One pulse per oscillator rising edge
  assign tick = s2_ff & ~s3_ff;

endmodule : scss_tick_sync

// ---- dv/system_clock_source_select_tb_top.sv ----
// Self-checking bench for the clock source select block.
// Assumes zero-wait AHB-Lite slave and oscillator pins made here from hclk.
`timescale 1ns/1ps
module system_clock_source_select_tb_top;
  import scss_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic cpu_halt = 1'b0;
  logic [3:0] osc = 4'h0;
  logic [3:0] run = 4'h5;
  wire hreadyout, hresp;
  wire [31:0] hrdata;
  wire frc_en, fxt_en, src_en, sxt_en, fpin, spin, sys_en, fp_en, sp_en, tmr;
  wire [1:0] frq;
  int ph [4] = '{0, 0, 0, 0};
  // Half periods in hclk cycles, one nibble per oscillator, index 0 lowest
  localparam logic [15:0] HALF = 16'h3523;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int c [4];
  logic [31:0] rd;

  scss_clock_select u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .int_fast_rc_osc_in(osc[0]),
    .ext_fast_crystal_osc_in(osc[1]), .int_slow_rc_osc_in(osc[2]),
    .ext_slow_crystal_osc_in(osc[3]), .fast_rc_opt(2'h2), .cpu_halt(cpu_halt),
    .int_fast_rc_osc_en(frc_en), .ext_fast_crystal_osc_en(fxt_en),
    .int_slow_rc_osc_en(src_en), .ext_slow_crystal_osc_en(sxt_en),
    .fast_rc_freq_field(frq), .fast_crystal_pins_osc_sel(fpin),
    .slow_crystal_pins_osc_sel(spin), .sysclk_en(sys_en), .fast_periph_en(fp_en),
    .slow_periph_en(sp_en), .timer_tick(tmr));

  // 10 MHz clock
  initial begin
    forever #50 hclk = ~hclk;
  end

  // Oscillator pins; a crystal stands still until the bench starts it
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (ph[i] >= int'(HALF[4 * i +: 4]) - 1) begin
        ph[i] <= 0;
        osc[i] <= ~osc[i] & run[i];
      end else begin
        ph[i] <= ph[i] + 1;
      end
    end
  end

  // Hang guard; the slow crystal start alone needs some 6200 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single transfer; hold each phase until hready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    // Register outputs settle after the edge that ends the data phase
    @(negedge hclk);
  endtask : xfer

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rchk

  // Switch waits for busy to clear, polled a bounded number of times
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (2) @(posedge hclk);
    do begin
      xfer(1'b0, SCSS_OFS_STATUS, 32'h0);
      k++;
    end while (rd[5] !== 1'b0 && k < 500);
  endtask : wait_idle

  task automatic wait_stable(input logic [7:0] a);
    int k;
    k = 0;
    do begin
      xfer(1'b0, a, 32'h0);
      k++;
    end while (rd[1] !== 1'b1 && k < 4000);
  endtask : wait_stable

  // Cycles between two system clock pulses, after one settling pulse
  task automatic per_chk(input string nm, input int exp);
    int k;
    k = 0;
    repeat (2) begin
      @(negedge hclk);
      while (sys_en !== 1'b1 && k < 3000) begin
        @(negedge hclk);
        k++;
      end
    end
    k = 0;
    do begin
      @(negedge hclk);
      k++;
    end while (sys_en !== 1'b1 && k < 3000);
    chk(nm, exp, k);
  endtask : per_chk

  // Pulse counts of system, fast, slow and timer enables over 120 cycles
  task automatic count4();
    c = '{0, 0, 0, 0};
    repeat (120) begin
      @(negedge hclk);
      c[0] += int'(sys_en === 1'b1);
      c[1] += int'(fp_en === 1'b1);
      c[2] += int'(sp_en === 1'b1);
      c[3] += int'(tmr === 1'b1);
    end
  endtask : count4

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk("frc_en", 32'h1, {31'h0, frc_en});
    chk("src_en", 32'h1, {31'h0, src_en});
    chk("fxt_en", 32'h0, {31'h0, fxt_en});
    chk("fast_pins", 32'h0, {31'h0, fpin});
    chk("slow_pins", 32'h0, {31'h0, spin});
    rchk("sysclk_ctrl", SCSS_OFS_SYSCLK_CTRL, 32'h0);
    rchk("fast_rc_ctrl", SCSS_OFS_FAST_RC_CTRL, 32'h3);
    rchk("fast_xtal_ctrl", SCSS_OFS_FAST_XTAL_CTRL, 32'h0);
    rchk("slow_xtal_ctrl", SCSS_OFS_SLOW_XTAL_CTRL, 32'h0);
    rchk("status", SCSS_OFS_STATUS, 32'h280);
    xfer(1'b1, 8'h14, 32'hff);
    rchk("unmapped", 8'h14, 32'h0);
    per_chk("rc_div1", 6);
  endtask : t_reset

  // Trim field follows software; mismatch flag clears
  task automatic t_trim();
    xfer(1'b1, SCSS_OFS_FAST_RC_CTRL, 32'h9);
    chk("trim", 32'h2, {30'h0, frq});
    rchk("status_trim", SCSS_OFS_STATUS, 32'h200);
  endtask : t_trim

  // Slow crystal: pins, enable, refusal before stable, then handover
  task automatic t_slow_xtal();
    xfer(1'b1, SCSS_OFS_SLOW_XTAL_CTRL, 32'h1);
    chk("sxt_en_nopin", 32'h0, {31'h0, sxt_en});
    xfer(1'b1, SCSS_OFS_SLOW_XTAL_CTRL, 32'h5);
    chk("sxt_en", 32'h1, {31'h0, sxt_en});
    chk("slow_pins_osc", 32'h1, {31'h0, spin});
    xfer(1'b1, SCSS_OFS_SYSCLK_CTRL, 32'he4);
    run[3] <= 1'b1;
    repeat (40) @(posedge hclk);
    rchk("status_refused", SCSS_OFS_STATUS, 32'h200);
    wait_stable(SCSS_OFS_SLOW_XTAL_CTRL);
    wait_idle();
    rchk("status_slow", SCSS_OFS_STATUS, 32'h217);
    per_chk("slow_xtal_per", 6);
  endtask : t_slow_xtal

  // Fast RC idle in slow mode follows its enable bit
  task automatic t_fast_off();
    xfer(1'b1, SCSS_OFS_FAST_RC_CTRL, 32'h8);
    count4();
    chk("frc_off", 32'h0, {31'h0, frc_en});
    chk("fp_off", 32'h0, c[1]);
    xfer(1'b1, SCSS_OFS_FAST_RC_CTRL, 32'h9);
    count4();
    chk("frc_on", 32'h1, {31'h0, frc_en});
    chk("fp_on", 32'h1, {31'h0, c[1] > 0});
  endtask : t_fast_off

  // Fast crystal source, then every divide code
  task automatic t_fast_xtal();
    xfer(1'b1, SCSS_OFS_FAST_XTAL_CTRL, 32'h1);
    chk("fxt_en_on", 32'h1, {31'h0, fxt_en});
    run[1] <= 1'b1;
    wait_stable(SCSS_OFS_FAST_XTAL_CTRL);
    for (int d = 0; d < 7; d++) begin
      xfer(1'b1, SCSS_OFS_SYSCLK_CTRL, 32'h8 | (d << 5));
      wait_idle();
      chk("status_div", 32'h208 | d, rd);
      per_chk("div_per", 4 << d);
    end
    chk("fast_pins_osc", 32'h1, {31'h0, fpin});
  endtask : t_fast_xtal

  // Halt stops the system clock; timer and idle clocks per bits
  task automatic t_halt();
    @(posedge hclk);
    cpu_halt <= 1'b1;
    count4();
    chk("halt_sys", 32'h0, c[0]);
    chk("halt_slow", 32'h0, c[2]);
    chk("halt_tmr", 32'h1, {31'h0, c[3] > 0});
    xfer(1'b1, SCSS_OFS_SYSCLK_CTRL, 32'hcb);
    count4();
    chk("idle_sys", 32'h0, c[0]);
    chk("idle_fast", 32'h1, {31'h0, c[1] > 0});
    chk("idle_slow", 32'h1, {31'h0, c[2] > 0});
    @(posedge hclk);
    cpu_halt <= 1'b0;
  endtask : t_halt

  task automatic conclude();
    $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_trim();
    t_slow_xtal();
    t_fast_off();
    t_fast_xtal();
    t_halt();
    conclude();
  end
endmodule : system_clock_source_select_tb_top
